//--- hw/mdio_slave.sv
// Serial management frame receiver and read-data driver
`timescale 1ns/10ps
`default_nettype none
module mdio_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Synchronised management pins
  input wire logic mdc_s,
  input wire logic mdio_s,
  input wire logic [4:0] phy_addr,
  // Register side
  input wire logic [15:0] rd_data,
  output logic [4:0] reg_addr_q,
  output logic [15:0] wr_data_q,
  output logic wr_stb_q,
  // Data pin drive
  output logic mdio_out_q,
  output logic mdio_oe_q
);

  typedef enum {S_IDLE, S_ST, S_OP, S_ADDR, S_TA, S_DATA} mst_e;

  mst_e st_q; // Frame state
  logic mdc_d_q; // Previous clock level
  logic rise; // Management clock rising edge
  logic [5:0] ones_q; // Preamble ones, saturating
  logic pre_ok_q; // Preamble seen, later frames may skip it
  logic [3:0] cnt_q; // Bit counter in field
  logic [1:0] op_q; // Opcode
  logic [15:0] sh_q; // Shift register
  logic mine_q; // Frame addresses this PHY
  logic is_rd_q; // Frame is a read

  assign rise = mdc_s & ~mdc_d_q;

  // Edge detect on the synchronised clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) mdc_d_q <= 1'b0;
    else mdc_d_q <= mdc_s;
  end

  // Frame decoder, one bit per rising clock edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      ones_q <= '0;
      pre_ok_q <= 1'b0;
      cnt_q <= '0;
      op_q <= '0;
      sh_q <= '0;
      mine_q <= 1'b0;
      is_rd_q <= 1'b0;
      reg_addr_q <= '0;
      wr_data_q <= '0;
      wr_stb_q <= 1'b0;
      mdio_out_q <= 1'b0;
      mdio_oe_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (rise) begin
        case (st_q)
          S_IDLE: begin
            if (mdio_s) begin
              // Count preamble ones, saturating at full length
              if (ones_q != phy_mgmt_pkg::PRE_LEN) begin
                ones_q <= ones_q + 6'h01;
              end
            end else begin
              ones_q <= '0;
              // Start bit right after a full preamble, or once armed
              if (pre_ok_q || ones_q == phy_mgmt_pkg::PRE_LEN) begin
                pre_ok_q <= 1'b1;
                st_q <= S_ST;
              end
            end
          end
          S_ST: begin
            cnt_q <= '0;
            st_q <= mdio_s ? S_OP : S_IDLE;
          end
          S_OP: begin
            op_q <= {op_q[0], mdio_s};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q != '0) begin
              cnt_q <= '0;
              if ({op_q[0], mdio_s} == phy_mgmt_pkg::OP_RD ||
                  {op_q[0], mdio_s} == phy_mgmt_pkg::OP_WR) begin
                st_q <= S_ADDR;
              end else begin
                // Bad opcode: need a full preamble again
                pre_ok_q <= 1'b0;
                st_q <= S_IDLE;
              end
            end
          end
          S_ADDR: begin
            sh_q <= {sh_q[14:0], mdio_s};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == phy_mgmt_pkg::ADDR_LAST) begin
              cnt_q <= '0;
              reg_addr_q <= {sh_q[3:0], mdio_s};
              mine_q <= (sh_q[8:4] == phy_addr);
              is_rd_q <= (op_q == phy_mgmt_pkg::OP_RD);
              st_q <= S_TA;
            end
          end
          S_TA: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == '0) begin
              // Read: drive the low turnaround bit
              if (is_rd_q && mine_q) begin
                mdio_oe_q <= 1'b1;
                mdio_out_q <= 1'b0;
              end else if (!is_rd_q && !mdio_s) begin
                pre_ok_q <= 1'b0;
                st_q <= S_IDLE;
              end
            end else begin
              cnt_q <= '0;
              st_q <= S_DATA;
              if (is_rd_q) begin
                mdio_out_q <= rd_data[15];
                sh_q <= {rd_data[14:0], 1'b0};
              end else if (mdio_s) begin
                // Bad write turnaround
                pre_ok_q <= 1'b0;
                st_q <= S_IDLE;
              end
            end
          end
          S_DATA: begin
            cnt_q <= cnt_q + 4'h1;
            if (is_rd_q) begin
              mdio_out_q <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
            end else begin
              sh_q <= {sh_q[14:0], mdio_s};
            end
            if (cnt_q == phy_mgmt_pkg::DATA_LAST) begin
              mdio_oe_q <= 1'b0;
              mdio_out_q <= 1'b0;
              st_q <= S_IDLE;
              if (!is_rd_q && mine_q) begin
                wr_data_q <= {sh_q[14:0], mdio_s};
                wr_stb_q <= 1'b1;
              end
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule : mdio_slave
`default_nettype wire

//--- hw/phy_mgmt_pkg.sv
// Constants shared by the PHY management register bank
package phy_mgmt_pkg;

  // Register and management frame widths
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 5;

  // Register offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h01;
  localparam logic [4:0] OFF_ID_HI = 5'h02;
  localparam logic [4:0] OFF_ID_LO = 5'h03;
  localparam logic [4:0] OFF_ADV = 5'h04;
  localparam logic [4:0] OFF_GIG_CTRL = 5'h09;
  localparam logic [4:0] OFF_GIG_STAT = 5'h0a;
  localparam logic [4:0] OFF_GIG_EXT = 5'h0f;

  // Control register bit positions
  localparam int unsigned B_RESET = 15;
  localparam int unsigned B_LOOP = 14;
  localparam int unsigned B_SPD_LO = 13;
  localparam int unsigned B_ANE = 12;
  localparam int unsigned B_PWD = 11;
  localparam int unsigned B_ISO = 10;
  localparam int unsigned B_RESTART = 9;
  localparam int unsigned B_DUPLEX = 8;
  localparam int unsigned B_RSV7 = 7;
  localparam int unsigned B_SPD_HI = 6;

  // Control register reset value (autoneg on, full duplex, speed 10b)
  localparam logic [15:0] CTRL_RST = 16'h1140;
  // Reset value of the writable negotiation and gigabit registers
  localparam logic [15:0] RW_RST = 16'h0000;

  // Forced speed codes, high bit first
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPD_RSV = 2'h3;

  // Management frame fields
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [3:0] ADDR_LAST = 4'h9;
  localparam logic [3:0] DATA_LAST = 4'hf;

endpackage : phy_mgmt_pkg

//--- hw/phy_mgmt_regs.sv
// PHY management register bank with basic control behaviour
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01, // Management address of this PHY
  parameter logic [15:0] ID_HIGH = 16'h0a5a, // Arbitrary identifier
  parameter logic [15:0] ID_LOW = 16'h1230 // Arbitrary identifier
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // Status words from the PHY core
  input wire logic [15:0] basic_status_in,
  input wire logic [15:0] gig_status_in,
  input wire logic [15:0] gig_ext_status_in,
  // Auto-negotiation engine handshake
  input wire logic an_begun,
  output logic an_start,
  output logic autoneg_enable,
  // Link mode controls
  output logic forced_mode,
  output logic [1:0] link_speed,
  output logic full_duplex,
  output logic power_down_ctl,
  output logic isolate,
  output logic soft_reset_busy,
  // MAC side data path
  input wire logic [7:0] mac_txd,
  input wire logic mac_tx_en,
  output logic [7:0] mac_rxd,
  output logic mac_rx_dv,
  // Line side data path
  input wire logic [7:0] line_rxd,
  input wire logic line_rx_dv,
  output logic [7:0] line_txd,
  output logic line_tx_en
);

  // Synchronised management pins
  logic mdc_s;
  logic mdio_s;

  // Register access from the frame decoder
  logic [4:0] reg_addr;
  logic [15:0] wr_data;
  logic wr_stb;
  logic [15:0] rd_data;
  logic ctrl_wr; // Write to the control register
  logic soft_rst; // Soft reset requested by this write
  logic restart_set; // Accepted restart request

  // Control register fields
  logic loop_q; // Loopback
  logic spd_lo_q; // Forced speed low bit
  logic ane_q; // Auto-negotiation enable
  logic pwd_q; // Power down
  logic iso_q; // Isolate
  logic restart_q; // Restart pending
  logic dup_q; // Duplex select
  logic rsv7_q; // Reserved writable bit
  logic spd_hi_q; // Forced speed high bit
  logic rst_busy_q; // Soft reset in progress

  // Writable negotiation and gigabit control registers
  logic [15:0] rw_q [phy_mgmt_pkg::OFF_ADV:phy_mgmt_pkg::OFF_GIG_CTRL];

  // Output flops
  logic an_start_q;
  logic forced_mode_q;
  logic [1:0] link_speed_q;
  logic full_duplex_q;
  logic [7:0] mac_rxd_q;
  logic mac_rx_dv_q;
  logic [7:0] line_txd_q;
  logic line_tx_en_q;

  // Pin synchronisers
  sync2 u_sync_mdc (
    .clk(clk),
    .reset_n(reset_n),
    .d(mdc),
    .q(mdc_s)
  );

  sync2 u_sync_mdio (
    .clk(clk),
    .reset_n(reset_n),
    .d(mdio_in),
    .q(mdio_s)
  );

  // Management frame engine, stays alive in power down and isolate
  mdio_slave u_mdio (
    .clk(clk),
    .reset_n(reset_n),
    .mdc_s(mdc_s),
    .mdio_s(mdio_s),
    .phy_addr(PHY_ADDR),
    .rd_data(rd_data),
    .reg_addr_q(reg_addr),
    .wr_data_q(wr_data),
    .wr_stb_q(wr_stb),
    .mdio_out_q(mdio_out),
    .mdio_oe_q(mdio_oe)
  );

  // Write decode
  assign ctrl_wr = wr_stb && (reg_addr == phy_mgmt_pkg::OFF_CTRL);
  assign soft_rst = ctrl_wr && wr_data[phy_mgmt_pkg::B_RESET];
  // Restart only honoured with negotiation enabled in the same write
  assign restart_set = ctrl_wr && !soft_rst &&
                       wr_data[phy_mgmt_pkg::B_RESTART] &&
                       wr_data[phy_mgmt_pkg::B_ANE];

  // Control register fields; soft reset loads defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loop_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_LOOP];
      spd_lo_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_SPD_LO];
      ane_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_ANE];
      pwd_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_PWD];
      iso_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_ISO];
      dup_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_DUPLEX];
      rsv7_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_RSV7];
      spd_hi_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_SPD_HI];
    end else if (soft_rst) begin
      // Defaults restored; rest of this write is dropped
      loop_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_LOOP];
      spd_lo_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_SPD_LO];
      ane_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_ANE];
      pwd_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_PWD];
      iso_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_ISO];
      dup_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_DUPLEX];
      rsv7_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_RSV7];
      spd_hi_q <= phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_SPD_HI];
    end else if (ctrl_wr) begin
      // Bits 5 to 0 have no storage
      loop_q <= wr_data[phy_mgmt_pkg::B_LOOP];
      spd_lo_q <= wr_data[phy_mgmt_pkg::B_SPD_LO];
      ane_q <= wr_data[phy_mgmt_pkg::B_ANE];
      pwd_q <= wr_data[phy_mgmt_pkg::B_PWD];
      iso_q <= wr_data[phy_mgmt_pkg::B_ISO];
      dup_q <= wr_data[phy_mgmt_pkg::B_DUPLEX];
      rsv7_q <= wr_data[phy_mgmt_pkg::B_RSV7];
      spd_hi_q <= wr_data[phy_mgmt_pkg::B_SPD_HI];
    end
  end

  // Soft reset busy flag, reads back as control bit 15
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_busy_q <= 1'b0;
    end else if (soft_rst) begin
      rst_busy_q <= 1'b1;
    end else if (rst_busy_q && (an_begun || !ane_q)) begin
      // Done once negotiation begins or forced mode is taken
      rst_busy_q <= 1'b0;
    end
  end

  // Restart bit: set by accepted request, cleared when engine begins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      restart_q <= 1'b0;
    end else if (restart_set) begin
      // Set wins over any clear in the same cycle
      restart_q <= 1'b1;
    end else if (soft_rst || an_begun) begin
      restart_q <= 1'b0;
    end else if (ctrl_wr && !wr_data[phy_mgmt_pkg::B_RESTART]) begin
      // Only the bit clears; the engine already has its start pulse
      restart_q <= 1'b0;
    end
  end

  // One-cycle start request to the negotiation engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      an_start_q <= 1'b0;
    end else begin
      // Soft reset restarts negotiation when it comes back enabled
      an_start_q <= restart_set ||
        (soft_rst && phy_mgmt_pkg::CTRL_RST[phy_mgmt_pkg::B_ANE]);
    end
  end

  // Writable registers at offsets 4 to 9
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = phy_mgmt_pkg::OFF_ADV;
           i <= phy_mgmt_pkg::OFF_GIG_CTRL; i++) begin
        rw_q[i] <= phy_mgmt_pkg::RW_RST;
      end
    end else if (soft_rst) begin
      for (int i = phy_mgmt_pkg::OFF_ADV;
           i <= phy_mgmt_pkg::OFF_GIG_CTRL; i++) begin
        rw_q[i] <= phy_mgmt_pkg::RW_RST;
      end
    end else if (wr_stb && reg_addr >= phy_mgmt_pkg::OFF_ADV &&
                 reg_addr <= phy_mgmt_pkg::OFF_GIG_CTRL) begin
      rw_q[reg_addr] <= wr_data;
    end
  end

  // Read multiplexer; every other offset reads zero
  always_comb begin
    rd_data = '0;
    case (reg_addr)
      phy_mgmt_pkg::OFF_CTRL: begin
        rd_data[phy_mgmt_pkg::B_RESET] = rst_busy_q;
        rd_data[phy_mgmt_pkg::B_LOOP] = loop_q;
        rd_data[phy_mgmt_pkg::B_SPD_LO] = spd_lo_q;
        rd_data[phy_mgmt_pkg::B_ANE] = ane_q;
        rd_data[phy_mgmt_pkg::B_PWD] = pwd_q;
        rd_data[phy_mgmt_pkg::B_ISO] = iso_q;
        rd_data[phy_mgmt_pkg::B_RESTART] = restart_q;
        rd_data[phy_mgmt_pkg::B_DUPLEX] = dup_q;
        rd_data[phy_mgmt_pkg::B_RSV7] = rsv7_q;
        rd_data[phy_mgmt_pkg::B_SPD_HI] = spd_hi_q;
      end
      // Read-only words with no write path
      phy_mgmt_pkg::OFF_STAT: rd_data = basic_status_in;
      phy_mgmt_pkg::OFF_ID_HI: rd_data = ID_HIGH;
      phy_mgmt_pkg::OFF_ID_LO: rd_data = ID_LOW;
      phy_mgmt_pkg::OFF_GIG_STAT: rd_data = gig_status_in;
      phy_mgmt_pkg::OFF_GIG_EXT: rd_data = gig_ext_status_in;
      default: begin
        if (reg_addr >= phy_mgmt_pkg::OFF_ADV &&
            reg_addr <= phy_mgmt_pkg::OFF_GIG_CTRL) begin
          rd_data = rw_q[reg_addr];
        end
      end
    endcase
  end

  // Forced link mode; ignored while negotiation is enabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      forced_mode_q <= 1'b0;
      link_speed_q <= phy_mgmt_pkg::SPD_1000;
      full_duplex_q <= 1'b1;
    end else begin
      forced_mode_q <= !ane_q;
      if (!ane_q) begin
        // Reserved code keeps the previous speed
        if ({spd_hi_q, spd_lo_q} != phy_mgmt_pkg::SPD_RSV) begin
          link_speed_q <= {spd_hi_q, spd_lo_q};
        end
        full_duplex_q <= dup_q;
      end
    end
  end

  // Data path: loopback, isolate and power down
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mac_rxd_q <= '0;
      mac_rx_dv_q <= 1'b0;
      line_txd_q <= '0;
      line_tx_en_q <= 1'b0;
    end else if (pwd_q || iso_q) begin
      // Port quiet in both directions
      mac_rxd_q <= '0;
      mac_rx_dv_q <= 1'b0;
      line_txd_q <= '0;
      line_tx_en_q <= 1'b0;
    end else if (loop_q) begin
      // Transmit returned to receive, line kept silent
      mac_rxd_q <= mac_txd;
      mac_rx_dv_q <= mac_tx_en;
      line_txd_q <= '0;
      line_tx_en_q <= 1'b0;
    end else begin
      mac_rxd_q <= line_rxd;
      mac_rx_dv_q <= line_rx_dv;
      line_txd_q <= mac_txd;
      line_tx_en_q <= mac_tx_en;
    end
  end

  // Outputs straight from flops
  assign an_start = an_start_q;
  assign autoneg_enable = ane_q;
  assign forced_mode = forced_mode_q;
  assign link_speed = link_speed_q;
  assign full_duplex = full_duplex_q;
  assign power_down_ctl = pwd_q;
  assign isolate = iso_q;
  assign soft_reset_busy = rst_busy_q;
  assign mac_rxd = mac_rxd_q;
  assign mac_rx_dv = mac_rx_dv_q;
  assign line_txd = line_txd_q;
  assign line_tx_en = line_tx_en_q;

endmodule : phy_mgmt_regs
`default_nettype wire

//--- hw/sync2.sv
// Two-stage synchroniser for one level
`timescale 1ns/10ps
`default_nettype none
module sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous level in, synchronised level out
  input wire logic d,
  output logic q
);

  logic meta_q; // First stage, read only by the second

  // Two flops in series
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : sync2
`default_nettype wire

//--- testbench/gigabit_phy_basic_control_regs_bench.sv
// Self-checking bench for the PHY management register bank
`timescale 1ns/10ps
`default_nettype none
module gigabit_phy_basic_control_regs_bench;
  localparam logic [15:0] ID_HI = 16'h5a01; // Arbitrary value
  localparam logic [15:0] ID_LO = 16'h0b70; // Arbitrary value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic mdc, m_drv, m_en, mdio_out, mdio_oe, mdio_wire;
  logic [15:0] st_b = 16'h0000, st_g = 16'h0000, st_x = 16'h0000;
  logic an_begun = 1'b0;
  logic an_start, autoneg_enable, forced_mode, full_duplex, isolate;
  logic power_down_ctl, soft_reset_busy, mac_rx_dv, line_tx_en;
  logic [1:0] link_speed;
  logic [7:0] mac_txd = 8'h00, line_rxd = 8'h00, mac_rxd, line_txd;
  logic mac_tx_en = 1'b0, line_rx_dv = 1'b0;
  logic [31:0] tseed = 32'h0000004a, mseed = 32'h0000004a;
  logic [15:0] rd, v;
  int failures = 0;
  int n_tests = 0;
  int n_start = 0;
  // Pull-up on the data line when nobody drives it
  assign mdio_wire = mdio_oe ? mdio_out : (m_en ? m_drv : 1'b1);
  always #2.5 clk = ~clk;
  phy_mgmt_regs #(.PHY_ADDR(5'h01), .ID_HIGH(ID_HI), .ID_LOW(ID_LO)) u_dut (
    .clk(clk), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .basic_status_in(st_b),
    .gig_status_in(st_g), .gig_ext_status_in(st_x), .an_begun(an_begun),
    .an_start(an_start), .autoneg_enable(autoneg_enable),
    .forced_mode(forced_mode), .link_speed(link_speed),
    .full_duplex(full_duplex), .power_down_ctl(power_down_ctl),
    .isolate(isolate), .soft_reset_busy(soft_reset_busy),
    .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .mac_rxd(mac_rxd),
    .mac_rx_dv(mac_rx_dv), .line_rxd(line_rxd), .line_rx_dv(line_rx_dv),
    .line_txd(line_txd), .line_tx_en(line_tx_en));
  mdio_master_model u_mdio (.mdc(mdc), .m_drv(m_drv), .m_en(m_en),
    .mdio_wire(mdio_wire));
  // Xorshift step
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : nxt
  // Random traffic on both data paths
  always @(posedge clk) begin
    #1;
    tseed = nxt(tseed);
    mac_txd = tseed[7:0];
    line_rxd = tseed[15:8];
    mac_tx_en = tseed[16];
    line_rx_dv = tseed[17];
  end
  // Count negotiation start pulses, sampled mid-cycle
  always @(negedge clk) begin
    if (an_start === 1'b1) n_start++;
  end
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Register access, writes followed by a settle gap
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_mdio.xfer(phy_mgmt_pkg::OP_WR, a, d, 1'b0, rd);
    repeat (10) @(posedge clk);
    #1;
  endtask : wr
  task automatic rdr(input logic [4:0] a);
    u_mdio.xfer(phy_mgmt_pkg::OP_RD, a, 16'h0000, 1'b0, rd);
  endtask : rdr
  // One-cycle negotiation-began pulse
  task automatic began;
    @(posedge clk);
    #1 an_begun = 1'b1;
    @(posedge clk);
    #1 an_begun = 1'b0;
  endtask : began
  // Data path check over a few cycles
  task automatic dpath(input logic lp, input logic quiet);
    logic [7:0] t, r;
    logic te, rv;
    logic [1:0] dv;
    repeat (6) begin
      @(posedge clk);
      t = mac_txd;
      r = line_rxd;
      te = mac_tx_en;
      rv = line_rx_dv;
      dv = lp ? {te, 1'b0} : {rv, te};
      #2;
      if (quiet) begin
        chk({14'h0, mac_rx_dv, line_tx_en}, 16'h0000);
        chk({mac_rxd, line_txd}, 16'h0000);
      end else begin
        chk({mac_rxd, line_txd}, {lp ? t : r, lp ? 8'h00 : t});
        chk({14'h0, mac_rx_dv, line_tx_en}, {14'h0, dv});
      end
    end
  endtask : dpath
  // Closing verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Watchdog
  initial begin
    #400000;
    failures++;
    finish_test;
  end
  // Main sequence
  initial begin
    logic [15:0] ro [5];
    logic [15:0] d;
    logic [1:0] c, sp;
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    mseed = nxt(mseed);
    st_b = mseed[15:0];
    st_g = mseed[31:16];
    st_x = mseed[15:0] ^ 16'h5aa5;
    u_mdio.xfer(phy_mgmt_pkg::OP_RD, 5'h00, 16'h0000, 1'b1, rd);
    chk(rd, phy_mgmt_pkg::CTRL_RST);
    chk({13'h0, autoneg_enable, link_speed}, 16'h0006);
    chk({15'h0, full_duplex}, 16'h0001);
    // Read-only registers ignore writes
    ro = '{st_b, ID_HI, ID_LO, st_g, st_x};
    foreach (ro[i]) begin
      d = (i == 0) ? 16'h0001 : (i == 3) ? 16'h000a : (i == 4) ? 16'h000f
        : 16'(i + 1);
      wr(d[4:0], ~ro[i]);
      rdr(d[4:0]);
      chk(rd, ro[i]);
    end
    // Reserved offsets read zero
    for (int a = 11; a < 32; a++) begin
      if (a != 15) begin
        wr(a[4:0], 16'hffff);
        rdr(a[4:0]);
        chk(rd, 16'h0000);
      end
    end
    // Writable registers hold random values
    for (int a = 4; a < 10; a++) begin
      mseed = nxt(mseed);
      wr(a[4:0], mseed[15:0]);
      rdr(a[4:0]);
      chk(rd, mseed[15:0]);
    end
    // Forced speed and duplex, bits 5 to 0 written as ones
    sp = 2'h2;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      d = {2'b00, c[0], 4'h0, c[1], 1'b0, c[1], 6'h3f};
      wr(5'h00, d);
      rdr(5'h00);
      chk(rd, d & 16'hffc0);
      if (c != 2'h3) sp = c;
      chk({14'h0, link_speed}, {14'h0, sp});
      chk({14'h0, forced_mode, full_duplex}, {14'h0, 1'b1, c[1]});
    end
    // Restart ignored while negotiation is off
    wr(5'h00, 16'h0200);
    rdr(5'h00);
    chk(rd, 16'h0000);
    chk(16'(n_start), 16'h0000);
    dpath(1'b0, 1'b0);
    wr(5'h00, 16'h4000);
    dpath(1'b1, 1'b0);
    wr(5'h00, 16'h0800);
    chk({14'h0, power_down_ctl, isolate}, 16'h0002);
    dpath(1'b0, 1'b1);
    wr(5'h00, 16'h0400);
    chk({14'h0, power_down_ctl, isolate}, 16'h0001);
    dpath(1'b0, 1'b1);
    // Restart reads one until negotiation begins
    wr(5'h00, 16'h1200);
    rdr(5'h00);
    chk(rd, 16'h1200);
    chk(16'(n_start), 16'h0001);
    began;
    rdr(5'h00);
    chk(rd, 16'h1000);
    // Soft reset restores defaults, busy until negotiation begins
    wr(5'h04, 16'h1234);
    wr(5'h00, 16'hc000);
    rdr(5'h00);
    chk(rd, 16'h9140);
    chk(16'(n_start), 16'h0002);
    rdr(5'h04);
    chk(rd, 16'h0000);
    began;
    rdr(5'h00);
    chk(rd, phy_mgmt_pkg::CTRL_RST);
    // Soft reset ends on entering forced mode
    wr(5'h00, 16'h8000);
    wr(5'h00, 16'h0100);
    chk({14'h0, soft_reset_busy, forced_mode}, 16'h0001);
    // Bad opcode demands a full preamble again
    u_mdio.xfer(2'b11, 5'h00, 16'h0000, 1'b0, rd);
    rdr(5'h00);
    chk(rd, 16'hffff);
    u_mdio.xfer(phy_mgmt_pkg::OP_RD, 5'h00, 16'h0000, 1'b1, rd);
    chk(rd, 16'h0100);
    finish_test;
  end
endmodule : gigabit_phy_basic_control_regs_bench
`default_nettype wire

//--- testbench/mdio_master_model.sv
// Management master that clocks frames onto the serial pins
`timescale 1ns/10ps
`default_nettype none
module mdio_master_model (
  // Serial management pins
  output logic mdc,
  output logic m_drv,
  output logic m_en,
  input wire logic mdio_wire
);
  // Clock stands low and the line is released between frames
  initial begin
    mdc = 1'b0;
    m_drv = 1'b1;
    m_en = 1'b0;
  end
  // One bit: data set while low, line sampled just before the rise
  task automatic bit_io(input logic b, input logic en, output logic s);
    m_drv = b;
    m_en = en;
    #24 s = mdio_wire;
    mdc = 1'b1;
    #24 mdc = 1'b0;
  endtask : bit_io
  // One frame, optional preamble, read data taken MSB first
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra,
      input logic [15:0] wd, input logic pre, output logic [15:0] rd);
    logic [31:0] f;
    logic s;
    f = {2'b01, op, 5'h01, ra, 2'b10, wd};
    if (pre) begin
      repeat (32) bit_io(1'b1, 1'b1, s);
    end
    for (int i = 31; i >= 0; i--) begin
      bit_io(f[i], !(op == phy_mgmt_pkg::OP_RD && i < 18), s);
      if (i < 16) rd[i] = s;
    end
    m_en = 1'b0;
  endtask : xfer
endmodule : mdio_master_model
`default_nettype wire

//--- testbench/phy_mgmt_regs_checker.sv
// Port-level assertions for the PHY management register bank
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_regs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Management data drive
  input wire logic mdio_out,
  input wire logic mdio_oe,
  // Negotiation handshake and mode
  input wire logic an_begun,
  input wire logic an_start,
  input wire logic autoneg_enable,
  input wire logic forced_mode,
  input wire logic [1:0] link_speed,
  input wire logic soft_reset_busy,
  input wire logic power_down_ctl,
  input wire logic isolate,
  // Data path valids
  input wire logic mac_rx_dv,
  input wire logic line_tx_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_start_pulse: assert property (an_start |=> !an_start)
    else $error("negotiation start longer than one cycle");
  chk_start_ane: assert property (an_start |-> autoneg_enable)
    else $error("negotiation start while disabled");
  chk_forced_mode: assert property (
    forced_mode == !$past(autoneg_enable))
    else $error("forced mode does not follow enable");
  chk_speed_code: assert property (link_speed != 2'h3)
    else $error("reserved speed code adopted");
  chk_busy_clear: assert property (
    soft_reset_busy && an_begun |=> !soft_reset_busy)
    else $error("reset busy kept after negotiation began");
  chk_busy_forced: assert property (
    soft_reset_busy && !autoneg_enable |=> !soft_reset_busy)
    else $error("reset busy kept in forced mode");
  chk_reset_start: assert property (
    $rose(soft_reset_busy) |-> ##[0:1] an_start)
    else $error("soft reset did not start negotiation");
  chk_pd_quiet: assert property (
    power_down_ctl |=> !mac_rx_dv && !line_tx_en)
    else $error("data moves in power down");
  chk_iso_quiet: assert property (
    isolate |=> !mac_rx_dv && !line_tx_en)
    else $error("data moves while isolated");
  chk_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround not driven low");
  // Main scenarios seen
  cov_start: cover property (an_start);
  cov_busy_end: cover property ($fell(soft_reset_busy));
  cov_read: cover property ($rose(mdio_oe));
  cov_forced: cover property (forced_mode);
endmodule : phy_mgmt_regs_checker
bind phy_mgmt_regs phy_mgmt_regs_checker u_chk (.clk(clk), .reset_n(reset_n),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .an_begun(an_begun),
  .an_start(an_start), .autoneg_enable(autoneg_enable),
  .forced_mode(forced_mode), .link_speed(link_speed),
  .soft_reset_busy(soft_reset_busy), .power_down_ctl(power_down_ctl),
  .isolate(isolate), .mac_rx_dv(mac_rx_dv), .line_tx_en(line_tx_en));
`default_nettype wire
